//--- smb_bus_unit.sv
// static memory bus unit: core requests to external static bus cycles
// assumes external devices answer on DATA_IN synchronously to CLK
`timescale 1ns/1ps
`default_nettype none
`include "smb_regs.svh"
module smb_bus_unit
   import smb_pkg::*;
(
   // clock, reset, freeze
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   // core bus request and answer
   input wire logic REQ_VALID,
   input wire smb_req_type REQ,
   output logic REQ_READY,
   output logic ACK,
   output logic [15:0] RDATA,
   // special select and read pulse
   input wire logic SPEC_VALID,
   input wire logic [1:0] SPEC_ZONE,
   output logic SPEC_ACK,
   // configuration
   input wire logic EARLY_WRITE_SEL,
   input wire smb_zone_cfg_type [3:0] ZONE_CFG,
   // external bus
   output logic [`SMB_ADDR_W-1:0] ADDR,
   output logic [15:0] DATA_OUT,
   output logic [1:0] DATA_OE,
   input wire logic [15:0] DATA_IN,
   output logic [2:0] ZONE_SELECT_N,
   output logic IO_SELECT_N,
   output logic BASE_SELECT_N,
   output logic RD_N,
   output logic [1:0] BYTE_WRITE_STROBE_N
);
   smb_state_type state_ff, nxt_state;
   logic pend_ff, nxt_pend, ready_ff;
   smb_req_type pend_ff_req;
   smb_zone_cfg_type cfg_ff, n_cfg, pcfg;
   logic [1:0] zone_ff, n_zone, pzone;
   logic write_ff, ew_ff, two_ff, burst_ff, piece_ff, word_ff, fast_ff;
   logic n_write, n_ew, n_piece, n_word;
   logic [`SMB_ADDR_W-1:0] base_ff, n_base;
   logic [15:0] wdata_ff, n_wdata, rdata_ff, n_bdata;
   logic ew_sel_ff;
   logic [1:0] lanes_ff, n_lanes;
   logic cbyte_ff, n_cbyte;
   logic start, last, piece_done, piece_inc, take_spec, need_gap, pfast;
   logic [`SMB_WAIT_W-1:0] wcnt;
   logic [`SMB_HOLD_W-1:0] hcnt, hload;
   logic sel_on, rd_on, wr_on, oe_on;
   logic [3:0] sel_vec;
   logic [3:0] sel_n_ff;
   logic base_n_ff, rd_n_ff, ack_ff, spec_ack_ff;
   logic [1:0] wr_n_ff, oe_ff;
   logic [15:0] dout_ff;
   logic [`SMB_ADDR_W-1:0] addr_ff;
   logic [7:0] rd_byte;

   // R1 zone decode and settings
   assign pzone = pend_ff_req.addr[`SMB_ZONE_HI:`SMB_ZONE_LO];
   assign pcfg = ZONE_CFG[pzone];
   // R25 fast read only for reads
   assign pfast = pcfg.fast_read_en & ~pend_ff_req.write;
   assign last = ~two_ff | piece_ff;

   // R4 merged idle between zones
   // R5 write to read idle
   assign need_gap = (write_ff & ew_ff & ~pend_ff_req.write)
      | (write_ff & ~ew_ff & pfast)
      | ((pzone != zone_ff) & (cfg_ff.idle_after_en | pcfg.idle_before_en));

   always_comb begin
      nxt_state = state_ff;
      piece_done = 1'b0;
      piece_inc = 1'b0;
      take_spec = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (SPEC_VALID) begin
               take_spec = 1'b1;
               nxt_state = ST_SPEC;
            end else if (pend_ff) begin
               nxt_state = pfast ? ST_FAST : ST_T1;
            end
         end
         ST_GAP: begin
            nxt_state = fast_ff ? ST_FAST : ST_T1;
         end
         ST_T1: begin
            // R16 waits after first phase
            nxt_state = (wcnt != '0) ? ST_TIW : ST_T2;
         end
         ST_TIW: begin
            if (wcnt == `SMB_WAIT_W'(1)) begin
               nxt_state = ST_T2;
            end
         end
         ST_T2: begin
            // R17 burst clock after second phase
            // R18 optional burst wait
            if (!write_ff && burst_ff && !piece_ff) begin
               piece_inc = 1'b1;
               nxt_state = cfg_ff.burst_wait_en ? ST_TBW : ST_T2B;
            end else if (write_ff && ew_ff) begin
               nxt_state = ST_T3;
            end else if (hcnt != '0) begin
               nxt_state = ST_HOLD;
            end else begin
               piece_done = 1'b1;
            end
         end
         ST_TBW: begin
            nxt_state = ST_T2B;
         end
         ST_T2B, ST_T3: begin
            // R19 holds after last phase
            if (hcnt != '0) begin
               nxt_state = ST_HOLD;
            end else begin
               piece_done = 1'b1;
            end
         end
         ST_HOLD: begin
            if (hcnt == `SMB_HOLD_W'(1)) begin
               piece_done = 1'b1;
            end
         end
         ST_FAST: begin
            piece_done = 1'b1;
         end
         ST_SPEC: begin
            // R20 idles after special pulse
            nxt_state = (hcnt != '0) ? ST_SGAP : ST_IDLE;
         end
         ST_SGAP: begin
            if (hcnt == `SMB_HOLD_W'(1)) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (piece_done) begin
         if (!last) begin
            // R6 second piece of split word
            piece_inc = 1'b1;
            nxt_state = fast_ff ? ST_FAST : ST_T1;
         end else if (pend_ff) begin
            nxt_state = need_gap ? ST_GAP : (pfast ? ST_FAST : ST_T1);
         end else begin
            nxt_state = ST_IDLE;
         end
      end
   end

   assign start = pend_ff
      & ((state_ff == ST_IDLE & ~SPEC_VALID) | (piece_done & last));

   // values of the cycle about to begin
   assign n_cfg = start ? pcfg : cfg_ff;
   assign n_zone = take_spec ? SPEC_ZONE : (start ? pzone : zone_ff);
   assign n_write = start ? pend_ff_req.write : write_ff;
   assign n_ew = start ? ew_sel_ff : ew_ff;
   assign n_word = start ? pend_ff_req.word : word_ff;
   assign n_base = start ? pend_ff_req.addr : base_ff;
   assign n_wdata = start ? pend_ff_req.wdata : wdata_ff;
   assign n_piece = start ? 1'b0 : (piece_inc | piece_ff);
   assign hload = take_spec ? ZONE_CFG[SPEC_ZONE].hold_cnt : n_cfg.hold_cnt;

   // R2 wait count
   smb_cycle_ctr #(.W(`SMB_WAIT_W)) u_wait (
      .clk(CLK),
      .rst(RESET),
      .ce(CE),
      .load(nxt_state == ST_T1),
      .load_val(n_cfg.wait_cnt),
      .dec(state_ff == ST_TIW),
      .count(wcnt)
   );

   // R3 hold count
   smb_cycle_ctr #(.W(`SMB_HOLD_W)) u_hold (
      .clk(CLK),
      .rst(RESET),
      .ce(CE),
      .load(nxt_state == ST_T1 || take_spec),
      .load_val(hload),
      .dec(state_ff == ST_HOLD || state_ff == ST_SGAP),
      .count(hcnt)
   );

   smb_lane_steer u_lane (
      .width16(n_cfg.width16),
      .word(n_word),
      .addr_lsb(n_base[0]),
      .piece(n_piece),
      .wdata(n_wdata),
      .lanes(n_lanes),
      .core_byte(n_cbyte),
      .bus_data(n_bdata)
   );

   // R26 one request slot stalls the core
   assign nxt_pend = (pend_ff & ~start) | (REQ_VALID & ready_ff);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         pend_ff <= 1'b0;
         ready_ff <= 1'b1;
         pend_ff_req <= '0;
      end else if (CE) begin
         pend_ff <= nxt_pend;
         ready_ff <= ~nxt_pend;
         if (REQ_VALID && ready_ff) begin
            pend_ff_req <= REQ;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_ff <= ST_IDLE;
         piece_ff <= 1'b0;
      end else if (CE) begin
         state_ff <= nxt_state;
         piece_ff <= n_piece;
      end
   end

   // R9 early write after reset
   // R11 normal read after reset
   always_ff @(posedge CLK) begin
      if (RESET) begin
         ew_sel_ff <= `SMB_EW_RST;
         cfg_ff <= `SMB_CFG_RST;
         zone_ff <= 2'h0;
         write_ff <= 1'b0;
         ew_ff <= `SMB_EW_RST;
         word_ff <= 1'b0;
         two_ff <= 1'b0;
         burst_ff <= 1'b0;
         fast_ff <= 1'b0;
         base_ff <= '0;
         wdata_ff <= 16'h0000;
      end else if (CE) begin
         ew_sel_ff <= EARLY_WRITE_SEL;
         if (start) begin
            cfg_ff <= pcfg;
            zone_ff <= pzone;
            write_ff <= pend_ff_req.write;
            ew_ff <= ew_sel_ff;
            word_ff <= pend_ff_req.word;
            // R7 word on narrow zone or odd word: two pieces
            two_ff <= pend_ff_req.word
               & (~pcfg.width16 | pend_ff_req.addr[0]);
            burst_ff <= pend_ff_req.word & ~pcfg.width16
               & ~pend_ff_req.write & pcfg.burstable_en & ~pfast;
            fast_ff <= pfast;
            base_ff <= pend_ff_req.addr;
            wdata_ff <= pend_ff_req.wdata;
         end
      end
   end

   // R8 unused read half ignored
   assign rd_byte = lanes_ff[1] ? DATA_IN[15:8] : DATA_IN[7:0];

   // R13 capture at end of second phase
   // R14 fast read capture
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata_ff <= 16'h0000;
         ack_ff <= 1'b0;
         spec_ack_ff <= 1'b0;
      end else if (CE) begin
         ack_ff <= piece_done & last;
         spec_ack_ff <= take_spec;
         if (!write_ff && (state_ff == ST_T2 || state_ff == ST_T2B
               || state_ff == ST_FAST)) begin
            if (lanes_ff == 2'h3) begin
               rdata_ff <= DATA_IN;
            end else if (cbyte_ff) begin
               rdata_ff[15:8] <= rd_byte;
            end else begin
               rdata_ff[7:0] <= rd_byte;
            end
         end
      end
   end

   always_comb begin
      // R24 read strobe from first wait or second phase
      rd_on = (nxt_state == ST_FAST) || (nxt_state == ST_SPEC)
         || (!n_write && (nxt_state inside
            {ST_TIW, ST_T2, ST_TBW, ST_T2B}));
      // R22 early write select from first wait
      // R23 late write select from first phase
      sel_on = (nxt_state == ST_FAST) || (nxt_state == ST_SPEC)
         || (!n_write && (nxt_state inside
            {ST_T1, ST_TIW, ST_T2, ST_TBW, ST_T2B}))
         || (n_write && (nxt_state inside {ST_TIW, ST_T2}))
         || (n_write && !n_ew && nxt_state == ST_T1);
      // R15 strobes held through third clock
      wr_on = n_write && ((nxt_state inside {ST_T1, ST_TIW, ST_T2})
         || (n_ew && nxt_state == ST_T3));
      // R12 no data in first clock
      // R16 data through waits
      oe_on = n_write
         && (nxt_state inside {ST_TIW, ST_T2, ST_T3, ST_HOLD});
      sel_vec = sel_on ? (4'h1 << n_zone) : 4'h0;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         sel_n_ff <= 4'hf;
         base_n_ff <= 1'b1;
         rd_n_ff <= 1'b1;
         wr_n_ff <= 2'h3;
         oe_ff <= 2'h0;
         dout_ff <= 16'h0000;
         addr_ff <= '0;
         lanes_ff <= 2'h1;
         cbyte_ff <= 1'b0;
      end else if (CE) begin
         sel_n_ff <= ~sel_vec;
         // R21 base memory select
         base_n_ff <= ~sel_vec[1] & ~sel_vec[2];
         rd_n_ff <= ~rd_on;
         wr_n_ff <= wr_on ? ~n_lanes : 2'h3;
         // R8 unused write half undriven
         oe_ff <= oe_on ? n_lanes : 2'h0;
         if (oe_on) begin
            dout_ff <= n_bdata;
         end
         // R17 address moves at burst clock
         if (nxt_state inside {ST_T1, ST_TBW, ST_T2B, ST_FAST}) begin
            addr_ff <= n_base + `SMB_ADDR_W'(n_piece);
            lanes_ff <= n_lanes;
            cbyte_ff <= n_cbyte;
         end
      end
   end

   assign REQ_READY = ready_ff;
   assign ACK = ack_ff;
   assign RDATA = rdata_ff;
   assign SPEC_ACK = spec_ack_ff;
   assign ADDR = addr_ff;
   assign DATA_OUT = dout_ff;
   assign DATA_OE = oe_ff;
   assign ZONE_SELECT_N = sel_n_ff[2:0];
   assign IO_SELECT_N = sel_n_ff[3];
   assign BASE_SELECT_N = base_n_ff;
   assign RD_N = rd_n_ff;
   assign BYTE_WRITE_STROBE_N = wr_n_ff;

   // checks
   logic ewr_tail;
   assign ewr_tail = write_ff & ew_ff
      & (state_ff == ST_T3 || state_ff == ST_HOLD);

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET || !CE);

   sequence late_wr_start;
      state_ff == ST_T1 && write_ff && !ew_ff && wcnt == 3'h0;
   endsequence
   sequence early_wr_start;
      state_ff == ST_T1 && write_ff && ew_ff && wcnt == 3'h0;
   endsequence

   wait_count_a: assert property ( // R2
      (state_ff == ST_T1 && wcnt == 3'h2)
      |=> (state_ff == ST_TIW)[*2] ##1 state_ff == ST_T2)
      else $error("wait clocks do not match count");
   hold_count_a: assert property ( // R19
      (state_ff inside {ST_T2, ST_T2B, ST_T3} && hcnt == 2'h2
         && nxt_state == ST_HOLD)
      |=> (state_ff == ST_HOLD)[*2] ##1 state_ff != ST_HOLD)
      else $error("hold clocks do not match count");
   gap_merge_a: assert property ( // R4
      (start && need_gap && state_ff != ST_IDLE)
      |=> state_ff == ST_GAP ##1 state_ff inside {ST_T1, ST_FAST})
      else $error("idle gap not single");
   ew_read_gap_a: assert property ( // R5
      (state_ff inside {ST_T1, ST_FAST} && !write_ff)
      |-> !$past(ewr_tail))
      else $error("read right after early write");
   write_len_a: assert property ( // R10
      (late_wr_start |=> state_ff == ST_T2 ##1 state_ff != ST_T3)
      and (early_wr_start |=> state_ff == ST_T2 ##1 state_ff == ST_T3))
      else $error("write cycle length wrong");
   first_clk_a: assert property ( // R12
      (state_ff == ST_T1 && write_ff) |-> DATA_OE == 2'h0)
      else $error("data driven in first clock");
   ew_third_a: assert property ( // R15
      (state_ff == ST_T3) |-> (&ZONE_SELECT_N && IO_SELECT_N
         && BYTE_WRITE_STROBE_N != 2'h3 && DATA_OE != 2'h0))
      else $error("third clock signals wrong");
   fast_single_a: assert property ( // R14
      (state_ff == ST_FAST) |-> (!RD_N && BYTE_WRITE_STROBE_N == 2'h3)
      ##1 !(state_ff inside {ST_TIW, ST_HOLD}))
      else $error("fast read lengthened or strobes wrong");
   spec_idle_a: assert property ( // R20
      (state_ff == ST_SPEC && hcnt == 2'h3)
      |=> (state_ff == ST_SGAP)[*3] ##1 state_ff == ST_IDLE)
      else $error("idles after special pulse wrong");
   base_sel_a: assert property ( // R21
      BASE_SELECT_N == (ZONE_SELECT_N[1] & ZONE_SELECT_N[2]))
      else $error("base select not the and of zone selects");
   ack_after_a: assert property ( // R26
      ACK |-> $past(state_ff) inside {ST_T2, ST_T2B, ST_T3, ST_HOLD,
         ST_FAST})
      else $error("answer not after last external clock");
   byte_lane_a: assert property ( // R8
      (DATA_OE != 2'h0 && !word_ff) |-> DATA_OE != 2'h3)
      else $error("both lanes driven on byte write");
endmodule
`default_nettype wire

//--- smb_bus_unit_tb.sv
// self-checking bench of the static memory bus unit
// assumes smb_pkg and the memory model are compiled first
`timescale 1ns/1ps
`default_nettype none
module smb_bus_unit_tb
   import smb_pkg::*;
;
   logic clk = 0, rst = 1, req_valid = 0, spec_valid = 0, ew = 1;
   smb_req_type req = '0;
   smb_zone_cfg_type [3:0] cfg = '0;
   logic req_ready, ack, spec_ack, base_n, rd_n, io_n;
   logic [15:0] rdata, dout, din, wr_seen;
   logic [1:0] oe, wstb_n, oe_seen;
   logic [19:0] addr;
   logic [2:0] zsel_n;
   int fails = 0, n_tests = 0, n_rd, n_wr, n_oe, n_base = 0, lat, l0;

   always #2 clk = ~clk;

   smb_bus_unit i_smb_bus_unit (.CLK(clk), .RESET(rst), .CE(1'b1),
      .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready), .ACK(ack),
      .RDATA(rdata), .SPEC_VALID(spec_valid), .SPEC_ZONE(2'h0),
      .SPEC_ACK(spec_ack), .EARLY_WRITE_SEL(ew), .ZONE_CFG(cfg),
      .ADDR(addr), .DATA_OUT(dout), .DATA_OE(oe), .DATA_IN(din),
      .ZONE_SELECT_N(zsel_n), .IO_SELECT_N(io_n), .BASE_SELECT_N(base_n),
      .RD_N(rd_n), .BYTE_WRITE_STROBE_N(wstb_n));

   smb_mem_model i_smb_mem_model (.clk(clk),
      .width16({cfg[3].width16, cfg[2].width16, cfg[1].width16,
                cfg[0].width16}),
      .addr(addr), .zsel_n(zsel_n), .iosel_n(io_n), .rd_n(rd_n),
      .wstb_n(wstb_n), .dout(dout), .oe(oe), .din(din), .wr_seen(wr_seen));

   // per-transfer counts of strobe, drive and read cycles
   always @(posedge clk) begin
      n_rd += int'(!rd_n);
      n_wr += int'(!(&wstb_n));
      n_oe += int'(|oe);
      oe_seen |= oe;
      n_base += int'(base_n !== (zsel_n[1] & zsel_n[2]));
   end

   function automatic logic [7:0] pat(input logic [19:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction
   function automatic logic [15:0] wexp(input logic [19:0] a);
      return a[0] ? {pat(a), pat(a + 20'h1)} : {pat(a + 20'h1), pat(a)};
   endfunction
   function automatic smb_zone_cfg_type mk(input logic [2:0] w,
      input logic [1:0] h, input logic bw, br, fr, w16);
      return {w, h, 2'b00, bw, br, fr, w16};
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic put(input logic wr, wd, input logic [19:0] a,
      input logic [15:0] d);
      @(negedge clk);
      req = '{write: wr, word: wd, addr: a, wdata: d};
      req_valid = 1;
      for (int i = 0; i < 50 && !req_ready; i++) @(negedge clk);
      @(negedge clk);
      req_valid = 0;
   endtask

   task automatic xfer(input logic wr, wd, input logic [19:0] a,
      input logic [15:0] d);
      n_rd = 0;
      n_wr = 0;
      n_oe = 0;
      oe_seen = 2'b00;
      put(wr, wd, a, d);
      for (lat = 1; lat < 200 && ack !== 1'b1; lat++) @(negedge clk);
      chk({15'h0, ack}, 16'h1);
   endtask

   // clocks from the first answer to the second of two queued requests
   task automatic ack_gap(output int n);
      for (n = 0; n < 200 && ack !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      for (n = 1; n < 200 && ack !== 1'b1; n++) @(negedge clk);
   endtask

   task automatic t_gap;
      int n;
      cfg[0] = mk(3'd0, 2'd0, 0, 0, 0, 1);
      put(1, 1, 20'h00040, 16'h1234);
      put(0, 1, 20'h00040, 16'h0);
      ack_gap(n);
      chk(16'(n), 16'd3);
      chk(rdata, wexp(20'h00040));
      cfg[0].idle_after_en = 1'b1;
      cfg[2].idle_before_en = 1'b1;
      put(0, 1, 20'h00040, 16'h0);
      put(0, 1, 20'h80040, 16'h0);
      ack_gap(n);
      chk(16'(n), 16'd3);
      ew = 0;
      cfg[2].fast_read_en = 1'b1;
      repeat (2) @(negedge clk);
      put(1, 0, 20'h80041, 16'h5a00);
      put(0, 1, 20'h80040, 16'h0);
      ack_gap(n);
      chk(16'(n), 16'd2);
      $display("test idle gap done");
   endtask

   task automatic t_read16;
      cfg[0] = mk(3'd2, 2'd0, 0, 0, 0, 1);
      xfer(0, 1, 20'h00010, 16'h0);
      chk(rdata, wexp(20'h00010));
      chk(16'(n_rd), 16'd3);
      xfer(0, 0, 20'h00013, 16'h0);
      chk({8'h0, rdata[15:8]}, {8'h0, pat(20'h00013)});
      xfer(0, 1, 20'h00015, 16'h0);
      chk(rdata, wexp(20'h00015));
      $display("test read16 done");
   endtask

   task automatic t_hold;
      cfg[0] = mk(3'd7, 2'd0, 0, 0, 0, 1);
      xfer(0, 1, 20'h00020, 16'h0);
      l0 = lat;
      chk(16'(n_rd), 16'd8);
      cfg[0] = mk(3'd7, 2'd3, 0, 0, 0, 1);
      xfer(0, 1, 20'h00020, 16'h0);
      chk(16'(lat - l0), 16'd3);
      $display("test wait hold done");
   endtask

   task automatic t_burst;
      cfg[1] = mk(3'd0, 2'd0, 0, 1, 0, 0);
      xfer(0, 1, 20'h40020, 16'h0);
      chk(rdata, wexp(20'h40020));
      chk(16'(n_rd), 16'd2);
      cfg[1] = mk(3'd0, 2'd0, 1, 1, 0, 0);
      xfer(0, 1, 20'h40022, 16'h0);
      chk(rdata, wexp(20'h40022));
      chk(16'(n_rd), 16'd3);
      cfg[1] = mk(3'd0, 2'd0, 0, 0, 0, 0);
      xfer(0, 1, 20'h40025, 16'h0);
      chk(rdata, wexp(20'h40025));
      $display("test burst done");
   endtask

   task automatic t_fast;
      cfg[2] = mk(3'd7, 2'd3, 0, 0, 1, 1);
      xfer(0, 1, 20'h80040, 16'h0);
      l0 = lat;
      chk(rdata, wexp(20'h80040));
      chk(16'(n_rd), 16'd1);
      cfg[2] = mk(3'd0, 2'd0, 0, 0, 1, 1);
      xfer(0, 1, 20'h80040, 16'h0);
      chk(16'(lat), 16'(l0));
      cfg[2] = mk(3'd0, 2'd0, 0, 0, 0, 1);
      xfer(0, 1, 20'h80040, 16'h0);
      chk(16'(lat - l0), 16'd1);
      $display("test fast read done");
   endtask

   task automatic t_write;
      for (int e = 0; e < 2; e++) begin
         ew = e[0];
         cfg[3] = mk(3'd1, 2'd2, 0, 0, 0, 1);
         repeat (2) @(negedge clk);
         xfer(1, 0, 20'hc0011, 16'hc35a);
         chk({14'h0, oe_seen}, 16'h2);
         chk({8'h0, wr_seen[15:8]}, 16'h00c3);
         chk(16'(n_oe), e ? 16'd5 : 16'd4);
         chk(16'(n_wr), e ? 16'd4 : 16'd3);
         cfg[3] = mk(3'd0, 2'd0, 0, 0, 0, 1);
         xfer(1, 1, 20'hc0012, 16'h1e2d);
         chk(wr_seen, 16'h1e2d);
         chk(16'(n_wr), e ? 16'd3 : 16'd2);
      end
      $display("test write done");
   endtask

   task automatic t_spec;
      int g;
      cfg[0] = mk(3'd0, 2'd3, 0, 0, 0, 1);
      @(negedge clk);
      spec_valid = 1;
      for (g = 0; g < 50 && !spec_ack; g++) @(negedge clk);
      spec_valid = 0;
      req = '{write: 1'b0, word: 1'b1, addr: 20'h00030, wdata: 16'h0};
      req_valid = 1;
      @(negedge clk);
      req_valid = 0;
      for (g = 0; g < 50 && zsel_n[0]; g++) @(negedge clk);
      chk({15'h0, g >= 3}, 16'h1);
      for (g = 0; g < 50 && ack !== 1'b1; g++) @(negedge clk);
      chk(rdata, wexp(20'h00030));
      $display("test special pulse done");
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(negedge clk);
      rst = 0;
      t_read16;
      t_hold;
      t_burst;
      t_fast;
      t_write;
      t_gap;
      t_spec;
      chk(16'(n_base), 16'h0);
      give_verdict;
   end

   // cuts a hang short well after the tests should end
   initial begin
      #40000;
      fails++;
      give_verdict;
   end
endmodule
`default_nettype wire

//--- smb_cycle_ctr.sv
// loadable down counter for wait and hold clocks
// assumes load and dec come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module smb_cycle_ctr #(
   parameter int W = 3
) (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic dec,
   // remaining count
   output logic [W-1:0] count
);
   logic [W-1:0] count_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         count_ff <= '0;
      end else if (ce) begin
         if (load) begin
            count_ff <= load_val;
         end else if (dec && count_ff != '0) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

   assign count = count_ff;
endmodule
`default_nettype wire

//--- smb_lane_steer.sv
// byte lane steering for one external bus piece
// assumes piece is 1 only on the second half of a split or burst word
`timescale 1ns/1ps
`default_nettype none
module smb_lane_steer (
   // piece description
   input wire logic width16,
   input wire logic word,
   input wire logic addr_lsb,
   input wire logic piece,
   input wire logic [15:0] wdata,
   // lane use
   output logic [1:0] lanes,
   output logic core_byte,
   output logic [15:0] bus_data
);
   logic full;
   logic pa0;
   logic [7:0] sel_byte;

   always_comb begin
      // R6 sixteen bit lanes
      full = width16 & word & ~addr_lsb;
      pa0 = addr_lsb ^ piece;
      core_byte = pa0;
      // R7 eight bit uses low lane
      if (full) begin
         lanes = 2'h3;
      end else if (width16 && pa0) begin
         lanes = 2'h2;
      end else begin
         lanes = 2'h1;
      end
      sel_byte = pa0 ? wdata[15:8] : wdata[7:0];
      bus_data = full ? wdata : {sel_byte, sel_byte};
   end
endmodule
`default_nettype wire

//--- smb_mem_model.sv
// external static memory model facing the bus unit
// assumes the unit's bus outputs are registered on clk
`timescale 1ns/1ps
`default_nettype none
module smb_mem_model (
   // clock and per-zone bus width
   input wire logic clk,
   input wire logic [3:0] width16,
   // bus from the unit
   input wire logic [19:0] addr,
   input wire logic [2:0] zsel_n,
   input wire logic iosel_n,
   input wire logic rd_n,
   input wire logic [1:0] wstb_n,
   input wire logic [15:0] dout,
   input wire logic [1:0] oe,
   // read answer and captured write bytes
   output logic [15:0] din,
   output logic [15:0] wr_seen
);
   logic [15:0] last = 16'h0000;
   logic sel;
   assign sel = !(&zsel_n) || !iosel_n;
   function automatic logic [7:0] pat(input logic [19:0] a);
      return a[7:0] ^ 8'ha5;
   endfunction
   // released bus shows the inverse of the last value
   always_comb begin
      if (sel && !rd_n && width16[addr[19:18]]) begin
         din = {pat(addr | 20'h00001), pat(addr & 20'hffffe)};
      end else if (sel && !rd_n) begin
         din = {~last[15:8], pat(addr)};
      end else begin
         din = ~last;
      end
   end
   always @(posedge clk) begin
      last <= din;
      if (!wstb_n[0] && oe[0]) wr_seen[7:0] <= dout[7:0];
      if (!wstb_n[1] && oe[1]) wr_seen[15:8] <= dout[15:8];
   end
endmodule
`default_nettype wire

//--- smb_pkg.sv
// types shared by the static memory bus unit files
// assumes smb_regs.svh is on the include path
`include "smb_regs.svh"
package smb_pkg;

   typedef struct packed {
      logic [`SMB_WAIT_W-1:0] wait_cnt;
      logic [`SMB_HOLD_W-1:0] hold_cnt;
      logic idle_before_en;
      logic idle_after_en;
      logic burst_wait_en;
      logic burstable_en;
      logic fast_read_en;
      logic width16;
   } smb_zone_cfg_type;

   typedef struct packed {
      logic write;
      logic word;
      logic [`SMB_ADDR_W-1:0] addr;
      logic [15:0] wdata;
   } smb_req_type;

   typedef enum logic [3:0] {
      ST_IDLE, ST_GAP, ST_T1, ST_TIW, ST_T2, ST_TBW, ST_T2B, ST_T3,
      ST_HOLD, ST_FAST, ST_SPEC, ST_SGAP
   } smb_state_type;

endpackage

//--- smb_regs.svh
// constants of the static memory bus unit: widths, zone field, resets
// assumes a single core clock domain and a synchronous reset
//
// Function
// R1 - decode each access into one of four zones and use that zone's settings
// R2 - wait states per zone programmable from zero to seven clocks
// R3 - hold clocks per zone programmable from zero to three clocks
// R4 - idle-before or idle-after between different zones adds one merged idle
// R5 - idle after early write before read; after late write before fast read
// R6 - 16-bit zone: even byte low lane, odd byte high, odd word split odd-even
// R7 - 8-bit zone: bytes on low lane; word as burst or two cycles
// R8 - single byte: unused half of data bus undriven on write, ignored on read
// R9 - global early-write select chooses write style; early write after reset
// R10 - no waits or holds: late write two clocks, early write three
// R11 - per-zone fast read gives one-clock read; normal read after reset
// R12 - first clock drives address; writes leave data bus undriven in it
// R13 - reads capture at end of second phase; writes drive data in it
// R14 - fast read asserts address, select and read strobe; captures at end
// R15 - early write third clock: select off, strobes next, address data held
// R16 - wait clocks sit between first and second phase; write data driven
// R17 - burst read adds burst clock after second phase; address changes there
// R18 - burst wait bit adds one wait clock before burst; address changes then
// R19 - hold clocks follow last phase; address and write data stay valid
// R20 - special select and read pulse is followed by zone hold count idles
// R21 - base memory select is AND of zone one and zone two selects
// R22 - early write strobes in first phase; data and select from next clock
// R23 - late write select at first phase; strobes end after second phase
// R24 - normal read strobe asserts at first wait or second phase
// R25 - fast reads ignore wait and hold settings
// R26 - core transaction stalls until last external cycle, then answers
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH

`define SMB_ADDR_W 20
`define SMB_ZONE_HI 19
`define SMB_ZONE_LO 18
`define SMB_WAIT_W 3
`define SMB_HOLD_W 2
`define SMB_EW_RST 1'b1
`define SMB_CFG_RST 11'h000

`endif
